// file: rtl/nsxtd_pkg.sv
// Functional notes
// RULE1: Nibble swap exchanges halves, flags untouched.
// RULE2: Swap destination bit picks working or file.
// RULE3: Literal XOR with working sets zero flag.
// RULE4: Literal XOR always writes working register.
// RULE5: Direction load copies working into selector 5..7.
// RULE6: Software should prefer direct direction register writes.
// RULE7: File XOR sets zero, destination bit, one cycle.
`default_nettype none
package nsxtd_pkg;
   localparam int                 INSTR_W       = 14;
   localparam int                 DATA_W        = 8;
   localparam int                 ADDR_W        = 7;
   localparam int                 DIR_COUNT     = 3;
   localparam logic [DATA_W-1:0]  WORK_RESET    = 8'h00;
   localparam logic [DATA_W-1:0]  DIR_RESET     = 8'hff;
   localparam logic               ZERO_RESET    = 1'b0;
   // Opcode patterns on instruction bits 13:8.
   localparam logic [5:0]         OP_SWAP       = 6'h0e;
   localparam logic [5:0]         OP_XOR_FILE   = 6'h06;
   localparam logic [3:0]         OP_XOR_LIT    = 4'he;
   localparam logic [1:0]         OP_XOR_LIT_HI = 2'h3;
   localparam logic [3:0]         OP_XOR_LIT_LO = 4'ha;
   // Direction load: bits 13:3 are 000_0000_1100 pattern, bits 2:0 select.
   localparam logic [10:0]        OP_DIR_LOAD   = 11'h00c;
   localparam logic [2:0]         DIR_SEL_MIN   = 3'h5;
   localparam logic [2:0]         DIR_SEL_MAX   = 3'h7;
   localparam int                 DEST_BIT      = 7;
   typedef enum logic [2:0]
   {
      NSXTD_NONE     = 3'b000,
      NSXTD_SWAP     = 3'b001,
      NSXTD_XOR_FILE = 3'b011,
      NSXTD_XOR_LIT  = 3'b010,
      NSXTD_DIR_LOAD = 3'b110
   } nsxtd_op_e;
endpackage
`default_nettype wire

// file: rtl/nsxtd_dir_regs.sv
`timescale 1ns/100ps
`default_nettype none
module nsxtd_dir_regs
(
   input  wire logic                              i_clock,
   input  wire logic                              i_rst,
   input  wire logic                              i_we,
   input  wire logic [1:0]                        i_sel,
   input  wire logic [nsxtd_pkg::DATA_W-1:0]      i_data,
   output logic      [nsxtd_pkg::DATA_W-1:0]      o_dir [nsxtd_pkg::DIR_COUNT]
);
   import nsxtd_pkg::*;

   logic [DATA_W-1:0] dir      [DIR_COUNT];
   logic [DATA_W-1:0] next_dir [DIR_COUNT];

   // Each direction register loads when its selector is written.
   genvar g;
   generate
      for (g = 0; g < DIR_COUNT; g++)
      begin : g_dir
         always_comb
         begin
            next_dir[g] = dir[g];
            if (i_we && (i_sel == 2'(g)))
            begin
               next_dir[g] = i_data;
            end
         end
         always_ff @(posedge i_clock or posedge i_rst)
         begin
            if (i_rst)
            begin
               dir[g] <= DIR_RESET;
            end
            else
            begin
               dir[g] <= next_dir[g];
            end
         end
         assign o_dir[g] = dir[g];
      end
   endgenerate
endmodule
`default_nettype wire

// file: rtl/nsxtd_core.sv
`timescale 1ns/100ps
`default_nettype none
module nsxtd_core
(
   input  wire logic                              i_clock,
   input  wire logic                              i_rst,
   input  wire logic                              i_valid,
   input  wire logic [nsxtd_pkg::INSTR_W-1:0]     i_instr,
   input  wire logic [nsxtd_pkg::DATA_W-1:0]      i_file_rdata,
   output logic      [nsxtd_pkg::ADDR_W-1:0]      o_file_addr,
   output logic                                   o_file_we,
   output logic      [nsxtd_pkg::DATA_W-1:0]      o_file_wdata,
   output logic      [nsxtd_pkg::DATA_W-1:0]      o_work,
   output logic                                   o_zero,
   output logic                                   o_illegal,
   output logic      [nsxtd_pkg::DATA_W-1:0]      o_dir [nsxtd_pkg::DIR_COUNT]
);
   import nsxtd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decode.

   // Classifies an instruction word into one of the handled operations.
   function automatic nsxtd_op_e decode(input logic [INSTR_W-1:0] w);
      logic [2:0] sel;
      sel = w[2:0];
      decode = NSXTD_NONE;
      if (w[13:8] == OP_SWAP)
      begin
         decode = NSXTD_SWAP;
      end
      else if (w[13:8] == OP_XOR_FILE)
      begin
         decode = NSXTD_XOR_FILE;
      end
      else if ((w[13:12] == OP_XOR_LIT_HI) && (w[11:8] == OP_XOR_LIT_LO))
      begin
         decode = NSXTD_XOR_LIT;
      end
      else if ((w[13:3] == OP_DIR_LOAD) && (sel >= DIR_SEL_MIN) && (sel <= DIR_SEL_MAX))
      begin
         decode = NSXTD_DIR_LOAD;
      end
   endfunction

   // Zero test shared by both exclusive-OR results.
   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      is_zero = (v == '0);
   endfunction

   nsxtd_op_e         op;
   logic              dest_file;
   logic [DATA_W-1:0] swapped;
   logic [DATA_W-1:0] xor_file;
   logic [DATA_W-1:0] xor_lit;

   // Operation results formed from the current word.
   always_comb
   begin
      op        = i_valid ? decode(i_instr) : NSXTD_NONE;
      dest_file = i_instr[DEST_BIT];
      swapped   = {i_file_rdata[3:0], i_file_rdata[7:4]}; // RULE1
      xor_file  = o_work ^ i_file_rdata;                   // RULE7
      xor_lit   = o_work ^ i_instr[DATA_W-1:0];            // RULE3
   end

   assign o_file_addr = i_instr[ADDR_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Working register and zero flag.

   logic [DATA_W-1:0] work;
   logic [DATA_W-1:0] next_work;
   logic              zero;
   logic              next_zero;

   // Next working register and zero flag per decoded operation; each one
   // completes in the cycle that takes it.
   always_comb
   begin
      next_work = work;
      next_zero = zero;
      case (op)
         NSXTD_SWAP:
         begin
            if (!dest_file)
            begin
               next_work = swapped;                        // RULE1 RULE2
            end
         end
         NSXTD_XOR_FILE:
         begin
            next_zero = is_zero(xor_file);                 // RULE7
            if (!dest_file)
            begin
               next_work = xor_file;                       // RULE7
            end
         end
         NSXTD_XOR_LIT:
         begin
            next_work = xor_lit;                           // RULE4
            next_zero = is_zero(xor_lit);                  // RULE3
         end
         default:
         begin
            next_zero = zero;                              // RULE5
         end
      endcase
   end

   // Registers the working register and the zero flag.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         work <= WORK_RESET;
         zero <= ZERO_RESET;
      end
      else
      begin
         work <= next_work;
         zero <= next_zero;
      end
   end

   assign o_work = work;
   assign o_zero = zero;

   ////////////////////////////////////////////////////////////////////////////
   // File register write port.

   logic              file_we;
   logic              next_file_we;
   logic [DATA_W-1:0] file_wdata;
   logic [DATA_W-1:0] next_file_wdata;

   // The strobe lasts one cycle when a file operation has its destination bit
   // set; the data hold until the next write-back so a slow sink can still see them.
   always_comb
   begin
      next_file_we    = 1'b0;
      next_file_wdata = file_wdata;
      if (dest_file && (op == NSXTD_SWAP))
      begin
         next_file_we    = 1'b1;                           // RULE2
         next_file_wdata = swapped;                        // RULE1
      end
      else if (dest_file && (op == NSXTD_XOR_FILE))
      begin
         next_file_we    = 1'b1;                           // RULE7
         next_file_wdata = xor_file;                       // RULE7
      end
   end

   // Registers the write port.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         file_we    <= 1'b0;
         file_wdata <= '0;
      end
      else
      begin
         file_we    <= next_file_we;
         file_wdata <= next_file_wdata;
      end
   end

   assign o_file_we    = file_we;
   assign o_file_wdata = file_wdata;

   ////////////////////////////////////////////////////////////////////////////
   // Refused words.

   logic illegal;
   logic next_illegal;

   // A valid word that decodes to none of the four operations changes no
   // state and raises the refusal pulse for one cycle.
   always_comb
   begin
      next_illegal = 1'b0;
      if (i_valid && (op == NSXTD_NONE))
      begin
         next_illegal = 1'b1;                              // RULE5
      end
   end

   // Registers the refusal pulse.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         illegal <= 1'b0;
      end
      else
      begin
         illegal <= next_illegal;
      end
   end

   assign o_illegal = illegal;

   ////////////////////////////////////////////////////////////////////////////
   // Direction registers, selector 5..7 maps to index 0..2.

   logic [1:0] dir_sel;

   // Offset selector into the register bank; flags are not touched here.
   always_comb
   begin
      dir_sel = 2'(i_instr[2:0] - DIR_SEL_MIN);                // RULE5
   end

   nsxtd_dir_regs i_nsxtd_dir_regs
   (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_we    (op == NSXTD_DIR_LOAD),                      // RULE5
      .i_sel   (dir_sel),
      .i_data  (work),
      .o_dir   (o_dir)
   );
endmodule
`default_nettype wire

// file: tb/nsxtd_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module nsxtd_core_sva
(
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_valid,
   input wire logic [13:0] i_instr,
   input wire logic [7:0]  i_file_rdata,
   input wire logic        o_file_we,
   input wire logic [7:0]  o_file_wdata,
   input wire logic [7:0]  o_work,
   input wire logic        o_zero,
   input wire logic        o_illegal,
   input wire logic [7:0]  o_dir [3]
);
   // Decoded views of the word on the input.
   wire logic sw = i_valid && i_instr[13:8] == 6'h0e;
   wire logic xl = i_valid && i_instr[13:8] == 6'h3a;
   wire logic xf = i_valid && i_instr[13:8] == 6'h06;
   wire logic dl = i_valid && i_instr[13:3] == 11'h00c && i_instr[2:0] >= 3'h5;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_swap_back; sw && i_instr[7]; endsequence
   chk_swap_back: assert property (s_swap_back |=> o_file_we &&
      o_file_wdata == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])}) else $error("swap write-back wrong");
   chk_swap_work: assert property (sw && !i_instr[7] |=> !o_file_we &&
      o_work == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])}) else $error("swap to work wrong");
   chk_swap_flags: assert property (sw |=> o_zero == $past(o_zero)) else $error("swap moved zero");
   chk_xlit_work: assert property (xl |=> o_work == ($past(o_work) ^ $past(i_instr[7:0])) &&
      o_zero == (o_work == 8'h00) && !o_file_we) else $error("literal xor wrong");
   chk_xfile_zero: assert property (xf |=> o_file_we == $past(i_instr[7]) &&
      o_zero == (($past(o_work) ^ $past(i_file_rdata)) == 8'h00)) else $error("file xor wrong");
   chk_dir_load: assert property (dl |=> o_dir[$past(i_instr[1:0]) - 2'h1] == $past(o_work) &&
      $stable(o_zero)) else $error("direction load wrong");
   chk_xfile_work: assert property (xf && !i_instr[7] |=> !o_file_we &&
      o_work == ($past(o_work) ^ $past(i_file_rdata))) else $error("file xor to work wrong");
   chk_xfile_back: assert property (xf && i_instr[7] |=> o_work == $past(o_work) &&
      o_file_wdata == ($past(o_work) ^ $past(i_file_rdata))) else $error("file xor write-back wrong");
   chk_dir_quiet: assert property (dl |=> !o_file_we &&
      o_work == $past(o_work)) else $error("direction load side effect");
   chk_refused_word: assert property (i_valid && !sw && !xl && !xf && !dl |=> o_illegal &&
      o_work == $past(o_work) && !o_file_we) else $error("refused word changed state");
   chk_taken_word: assert property (sw || xl || xf || dl |=> !o_illegal) else $error("taken word refused");
endmodule
bind nsxtd_core nsxtd_core_sva i_nsxtd_core_sva (.i_clock, .i_rst, .i_valid, .i_instr, .i_file_rdata,
   .o_file_we, .o_file_wdata, .o_work, .o_zero, .o_illegal, .o_dir);
`default_nettype wire

// file: tb/nsxtd_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module nsxtd_core_tb_top;
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_valid = 1'b0;
   logic [13:0] i_instr = 14'h0000;
   logic [7:0]  i_file_rdata = 8'h00;
   logic [6:0]  o_file_addr;
   logic        o_file_we;
   logic [7:0]  o_file_wdata;
   logic [7:0]  o_work;
   logic        o_zero;
   logic        o_illegal;
   logic [7:0]  o_dir [3];
   int          n_errors = 0;
   int          cmp_count = 0;
   // Clock at 50 MHz.
   always #10 i_clock = ~i_clock;
   nsxtd_core i_nsxtd_core (.i_clock, .i_rst, .i_valid, .i_instr, .i_file_rdata, .o_file_addr,
      .o_file_we, .o_file_wdata, .o_work, .o_zero, .o_illegal, .o_dir);
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Compares work, zero and write strobe after an instruction.
   task automatic chk3(input logic [7:0] w, input logic z, input logic we);
      chk("work", w, o_work);
      chk("zero", {7'h00, z}, {7'h00, o_zero});
      chk("file_we", {7'h00, we}, {7'h00, o_file_we});
   endtask
   // Presents one word for one edge; valid stays up for back-to-back issue.
   task automatic issue(input logic [13:0] ins, input logic [7:0] rd);
      i_valid = 1'b1;
      i_instr = ins;
      i_file_rdata = rd;
      #1 chk("file_addr", {1'b0, ins[6:0]}, {1'b0, o_file_addr});
      @(posedge i_clock);
      #1;
   endtask
   task automatic t_xor_lit;
      issue(14'h3ab5, 8'h00);
      chk3(8'hb5, 1'b0, 1'b0);
      issue(14'h3aaf, 8'hff);
      chk3(8'h1a, 1'b0, 1'b0);
      issue(14'h3a1a, 8'h00);
      chk3(8'h00, 1'b1, 1'b0);
   endtask
   task automatic t_swap;
      issue(14'h0e10, 8'ha5);
      chk3(8'h5a, 1'b1, 1'b0);
      issue(14'h0e90, 8'h3c);
      chk3(8'h5a, 1'b1, 1'b1);
      chk("swap_wdata", 8'hc3, o_file_wdata);
   endtask
   task automatic t_xor_file;
      issue(14'h0690, 8'h5b);
      chk3(8'h5a, 1'b0, 1'b1);
      chk("xor_wdata", 8'h01, o_file_wdata);
      issue(14'h0610, 8'h5a);
      chk3(8'h00, 1'b1, 1'b0);
   endtask
   task automatic t_dir;
      logic [7:0] w;
      w = 8'h00;
      for (int s = 5; s <= 7; s++)
      begin
         w = w ^ 8'h90 ^ s[7:0];
         issue(14'h3a90 | s[13:0], 8'h00);
         issue(14'h0060 | s[13:0], 8'h00);
         chk("dir", w, o_dir[s - 5]);
         chk3(w, 1'b0, 1'b0);
      end
      issue(14'h0064, 8'h00);
      chk3(w, 1'b0, 1'b0);
      chk("illegal", 8'h01, {7'h00, o_illegal});
   endtask
   // Mid-run reset returns every registered output to its reset value at once (direction registers to ff); the next words still execute.
   task automatic t_reset;
      i_valid = 1'b0;
      i_rst = 1'b1;
      #1;
      chk3(8'h00, 1'b0, 1'b0);
      chk("wdata_reset", 8'h00, o_file_wdata);
      chk("illegal_reset", 8'h00, {7'h00, o_illegal});
      for (int k = 0; k < 3; k++)
         chk("dir_reset", 8'hff, o_dir[k]);
      @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      issue(14'h3a3c, 8'h00);
      chk3(8'h3c, 1'b0, 1'b0);
      chk("illegal", 8'h00, {7'h00, o_illegal});
      issue(14'h3a3c, 8'h00);
      issue(14'h0067, 8'h00);
      chk3(8'h00, 1'b1, 1'b0);
      chk("dir", 8'h00, o_dir[2]);
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog far beyond the few dozen cycles the tests need.
   initial
   begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
   // Main sequence.
   initial
   begin
      repeat (3) @(posedge i_clock);
      #1;
      chk3(8'h00, 1'b0, 1'b0);
      chk("dir_reset", 8'hff, o_dir[2]);
      i_rst = 1'b0;
      t_xor_lit;
      t_swap;
      t_xor_file;
      // The direction scenarios and the reset test issue the legacy load; all other stimulus keeps to XOR and swap operations.
      t_dir;
      t_reset;
      i_valid = 1'b0;
      @(posedge i_clock);
      #1;
      tally_and_finish;
   end
endmodule
`default_nettype wire
